/* File: verilog/ieu_pkg.sv */
// package for the interrupt entry/return sequencer: constants and carrier types
package ieu_pkg;
   // core word and vector table geometry
   localparam int          W             = 16;
   localparam int          NVEC          = 32;
   localparam int          NMASK         = 30;
   localparam logic [4:0]  IDX_RST       = 5'h1F;
   localparam logic [4:0]  IDX_NMI       = 5'h1E;
   localparam logic [15:0] VEC_BASE      = 16'hFFC0;
   localparam logic [15:0] VEC_TOP       = 16'hFFFF;
   localparam logic [15:0] SR_CLEAR      = 16'h0000;
   localparam int          SR_IRQ_EN_BIT = 3;
   localparam int          SR_SLEEP_BIT  = 4;

   // latencies in core cycles from acceptance: entry to first handler instruction, return to resumed code
   localparam int ENTRY_CYC_BASE = 6;
   localparam int ENTRY_CYC_EXT  = 5;
   localparam int RET_CYC_BASE   = 5;
   localparam int RET_CYC_EXT    = 3;

   // sequence steps; outputs show two cycles after acceptance plus the step
   localparam int         STEP_W         = 3;
   localparam logic [2:0] STEP_PUSH_PC   = 3'h0;
   localparam logic [2:0] STEP_PUSH_SR   = 3'h1;
   localparam logic [2:0] STEP_VEC       = 3'h2;
   localparam logic [2:0] STEP_VEC_DATA  = 3'h3;
   localparam logic [2:0] STEP_SR_DATA   = 3'h0;
   localparam logic [2:0] STEP_PC_DATA   = 3'h1;
   localparam logic [2:0] STEP_RST_VEC   = 3'h0;
   localparam logic [2:0] STEP_RST_LOAD  = 3'h1;
   localparam logic [2:0] ENTRY_LAST_EXT  = 3'(ENTRY_CYC_EXT - 2);
   localparam logic [2:0] ENTRY_LAST_BASE = 3'(ENTRY_CYC_BASE - 2);
   localparam logic [2:0] RET_LAST_EXT    = 3'(RET_CYC_EXT - 2);
   localparam logic [2:0] RET_LAST_BASE   = 3'(RET_CYC_BASE - 2);

   // register byte offsets
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_NMI_EN  = 8'h04;
   localparam logic [7:0] REG_NMI_FLG = 8'h08;
   localparam logic [7:0] REG_RST_FLG = 8'h0C;
   localparam logic [7:0] REG_SINGLE  = 8'h10;
   localparam logic [7:0] REG_STATUS  = 8'h14;

   // field positions
   localparam int CTRL_EXT_BIT  = 0;
   localparam int NMI_PIN       = 0;
   localparam int NMI_OSC       = 1;
   localparam int NMI_FLASH     = 2;
   localparam int RST_POWER_ON  = 0;
   localparam int RST_PIN       = 1;
   localparam int RST_WDOG      = 2;
   localparam int RST_KEY       = 3;
   localparam int RST_ILL_FETCH = 4;

   typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_RET, ST_RSTV} ieu_state_t;

   // stack port towards the core
   typedef struct packed {
      logic          push;
      logic          pop;
      logic [W-1:0]  data;
   } ieu_stk_t;

   // register load port towards the core
   typedef struct packed {
      logic          pc_load;
      logic [W-1:0]  pc_val;
      logic          sr_load;
      logic [W-1:0]  sr_val;
   } ieu_core_t;
endpackage

/* File: verilog/ieu_prio_enc.sv */
// fixed-priority encoder: highest set request index wins
`timescale 1ns/1ps
module ieu_prio_enc (
   input  wire logic [31:0] req_i,
   output logic             any_o,
   output logic [4:0]       idx_o
);
   // later iterations overwrite, so the highest index survives
   always_comb begin
      idx_o = '0;
      for (int i = 0; i < ieu_pkg::NVEC; i++) begin
         if (req_i[i]) begin
            idx_o = 5'(i);
         end
      end
   end

   assign any_o = |req_i;
endmodule // ieu_prio_enc

/* File: verilog/ieu_entry_return.sv */
// interrupt entry and return sequencer with wishbone control registers
// How it works
// [RQ1] entry takes 5 cycles on extended core, 6 on base core
// [RQ2] entry starts only at an instruction boundary, never mid-instruction
// [RQ3] first push is the program counter of the next instruction
// [RQ4] second push is the status word, taken before it is cleared
// [RQ5] highest-priority pending request is selected
// [RQ6] single-source flags clear on acceptance; multi-source flags stay for software
// [RQ7] status word is cleared on entry, ending low power and global enable
// [RQ8] finally the vector word is loaded into the program counter
// [RQ9] return takes 5 cycles on base core, 3 on extended core
// [RQ10] return first pops the status word, restoring all its bits
// [RQ11] return then pops the program counter and resumes
// [RQ12] global enable set in a handler lets any pending request nest
// [RQ13] vectors are words 0FFC0h..0FFFEh, priority rising with address
// [RQ14] software places full 16-bit handler addresses in vectors
// [RQ15] all reset sources share vector 0FFFEh with priority 31
// [RQ16] pin, oscillator and flash events share vector 0FFFCh, priority 30
// [RQ17] software gives every used vector a handler, maybe a shared one
// [RQ18] byte-wide enable and flag registers take byte accesses
// [RQ19] maskable needs own and global enable; non-maskable only its own
// [RQ20] accepting a non-maskable request clears all three non-maskable enables
// [RQ21] owner of a single-source vector gets a one-cycle acknowledge
`timescale 1ns/1ps
module ieu_entry_return (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   input  wire logic             instr_done_i,
   input  wire logic             ret_req_i,
   input  wire logic [15:0]      pc_i,
   input  wire logic [15:0]      sr_i,
   input  wire logic [15:0]      pop_data_i,
   input  wire logic [15:0]      vec_data_i,
   input  wire logic [29:0]      irq_i,
   input  wire logic             nmi_pin_evt_i,
   input  wire logic             osc_fault_evt_i,
   input  wire logic             flash_acc_viol_i,
   input  wire logic             pin_reset_evt_i,
   input  wire logic             watchdog_evt_i,
   input  wire logic             key_viol_evt_i,
   input  wire logic             illegal_fetch_evt_i,
   output ieu_pkg::ieu_stk_t     stk_o,
   output ieu_pkg::ieu_core_t    core_o,
   output logic                  vec_rd_o,
   output logic      [15:0]      vec_addr_o,
   output logic      [29:0]      irq_ack_o,
   output logic                  busy_o,
   output logic                  isr_start_o,
   output logic                  ret_done_o
);
   // byte-lane merge used by every writable register
   function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   // word address of a vector slot
   function automatic logic [15:0] vec_addr(input logic [4:0] idx);
      return ieu_pkg::VEC_BASE + {10'h000, idx, 1'b0};
   endfunction

   ieu_pkg::ieu_state_t state_q, state_d;
   logic [2:0]          step_q, step_d;
   logic [4:0]          sel_q, sel_d;
   logic                ext_q, ext_d;
   logic [15:0]         pc_sav_q, pc_sav_d, sr_sav_q, sr_sav_d;
   ieu_pkg::ieu_stk_t   stk_d;
   ieu_pkg::ieu_core_t  core_d;
   logic                vec_rd_d, busy_d, isr_start_d, ret_done_d;
   logic [15:0]         vec_addr_d;
   logic [29:0]         irq_ack_d;
   logic                accept, ret_go, nmi_clr;
   logic                ctrl_ext_q, ctrl_ext_d, ack_d;
   logic [2:0]          nmi_en_q, nmi_en_d, nmi_flg_q, nmi_flg_d, nmi_evt, nmi_wclr;
   logic [4:0]          rst_flg_q, rst_flg_d, rst_evt_v, rst_wclr;
   logic [29:0]         single_q, single_d;
   logic [31:0]         rdat_d, wmask;
   logic                wr, rst_evt, pend_any, irq_on, boundary;
   logic [31:0]         pend;
   logic [4:0]          pend_idx;

   // request gathering: masked sources need global enable, nmi only its own
   assign irq_on   = sr_i[ieu_pkg::SR_IRQ_EN_BIT];
   assign boundary = instr_done_i | sr_i[ieu_pkg::SR_SLEEP_BIT];        // RQ2
   assign pend     = {1'b0, |(nmi_flg_q & nmi_en_q), irq_i & {30{irq_on}}}; // RQ19 RQ16
   assign rst_evt  = |{pin_reset_evt_i, watchdog_evt_i, key_viol_evt_i,
                       illegal_fetch_evt_i};

   ieu_prio_enc u_enc (
      .req_i (pend),
      .any_o (pend_any),
      .idx_o (pend_idx)
   );

   // sequencer next state and core-facing outputs
   always_comb begin
      state_d     = state_q;
      step_d      = 3'(step_q + 3'h1);
      sel_d       = sel_q;
      ext_d       = ext_q;
      pc_sav_d    = pc_sav_q;
      sr_sav_d    = sr_sav_q;
      stk_d       = '0;
      core_d      = '0;
      vec_rd_d    = 1'b0;
      vec_addr_d  = vec_addr_o;
      irq_ack_d   = '0;
      isr_start_d = 1'b0;
      ret_done_d  = 1'b0;
      accept      = 1'b0;
      ret_go      = 1'b0;
      nmi_clr     = 1'b0;
      // reset sources abort whatever runs and fetch the top vector
      if (rst_evt) begin
         state_d = ieu_pkg::ST_RSTV;                                     // RQ15
         step_d  = ieu_pkg::STEP_RST_VEC;
         sel_d   = ieu_pkg::IDX_RST;
      end else begin
         unique case (state_q)
            ieu_pkg::ST_IDLE: begin
               step_d = '0;
               if (ret_req_i) begin
                  ret_go    = 1'b1;
                  state_d   = ieu_pkg::ST_RET;
                  ext_d     = ctrl_ext_q;
                  stk_d.pop = 1'b1;                                      // RQ10
               end else if (boundary && pend_any) begin                  // RQ2 RQ12
                  accept   = 1'b1;
                  state_d  = ieu_pkg::ST_ENTRY;
                  sel_d    = pend_idx;                                   // RQ5
                  ext_d    = ctrl_ext_q;
                  pc_sav_d = pc_i;
                  sr_sav_d = sr_i;                                       // RQ4
                  nmi_clr  = (pend_idx == ieu_pkg::IDX_NMI);             // RQ20
               end
            end
            ieu_pkg::ST_ENTRY: begin
               if (step_q == ieu_pkg::STEP_PUSH_PC) begin
                  stk_d.push = 1'b1;                                     // RQ3
                  stk_d.data = pc_sav_q;
               end
               if (step_q == ieu_pkg::STEP_PUSH_SR) begin
                  stk_d.push = 1'b1;                                     // RQ4
                  stk_d.data = sr_sav_q;
               end
               if (step_q == ieu_pkg::STEP_VEC) begin
                  vec_rd_d       = 1'b1;
                  vec_addr_d     = vec_addr(sel_q);                      // RQ13
                  core_d.sr_load = 1'b1;                                 // RQ7
                  core_d.sr_val  = ieu_pkg::SR_CLEAR;
                  if (sel_q < ieu_pkg::IDX_NMI && single_q[sel_q]) begin
                     irq_ack_d[sel_q] = 1'b1;                            // RQ6 RQ21
                  end
               end
               if (step_q == ieu_pkg::STEP_VEC_DATA) begin
                  core_d.pc_load = 1'b1;                                 // RQ8
                  core_d.pc_val  = vec_data_i;
               end
               if (step_q == (ext_q ? ieu_pkg::ENTRY_LAST_EXT : ieu_pkg::ENTRY_LAST_BASE)) begin
                  isr_start_d = 1'b1;                                    // RQ1
                  state_d     = ieu_pkg::ST_IDLE;
               end
            end
            ieu_pkg::ST_RET: begin
               if (step_q == ieu_pkg::STEP_SR_DATA) begin
                  core_d.sr_load = 1'b1;                                 // RQ10
                  core_d.sr_val  = pop_data_i;
                  stk_d.pop      = 1'b1;                                 // RQ11
               end
               if (step_q == ieu_pkg::STEP_PC_DATA) begin
                  core_d.pc_load = 1'b1;                                 // RQ11
                  core_d.pc_val  = pop_data_i;
               end
               if (step_q == (ext_q ? ieu_pkg::RET_LAST_EXT : ieu_pkg::RET_LAST_BASE)) begin
                  ret_done_d = 1'b1;                                     // RQ9
                  state_d    = ieu_pkg::ST_IDLE;
               end
            end
            ieu_pkg::ST_RSTV: begin
               if (step_q == ieu_pkg::STEP_RST_VEC) begin
                  vec_rd_d       = 1'b1;
                  vec_addr_d     = vec_addr(ieu_pkg::IDX_RST);           // RQ15
                  core_d.sr_load = 1'b1;
                  core_d.sr_val  = ieu_pkg::SR_CLEAR;
               end
               if (step_q == ieu_pkg::STEP_RST_LOAD) begin
                  core_d.pc_load = 1'b1;
                  core_d.pc_val  = vec_data_i;
                  isr_start_d    = 1'b1;
                  state_d        = ieu_pkg::ST_IDLE;
               end
            end
         endcase
      end
      busy_d = (state_d != ieu_pkg::ST_IDLE);
   end

   // sequencer registers; reset starts the reset-vector fetch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q     <= ieu_pkg::ST_RSTV;
         step_q      <= ieu_pkg::STEP_RST_VEC;
         sel_q       <= ieu_pkg::IDX_RST;
         ext_q       <= 1'b0;
         pc_sav_q    <= '0;
         sr_sav_q    <= '0;
         stk_o       <= '0;
         core_o      <= '0;
         vec_rd_o    <= 1'b0;
         vec_addr_o  <= ieu_pkg::VEC_TOP;
         irq_ack_o   <= '0;
         busy_o      <= 1'b1;
         isr_start_o <= 1'b0;
         ret_done_o  <= 1'b0;
      end else begin
         state_q     <= state_d;
         step_q      <= step_d;
         sel_q       <= sel_d;
         ext_q       <= ext_d;
         pc_sav_q    <= pc_sav_d;
         sr_sav_q    <= sr_sav_d;
         stk_o       <= stk_d;
         core_o      <= core_d;
         vec_rd_o    <= vec_rd_d;
         vec_addr_o  <= vec_addr_d;
         irq_ack_o   <= irq_ack_d;
         busy_o      <= busy_d;
         isr_start_o <= isr_start_d;
         ret_done_o  <= ret_done_d;
      end
   end

   // sticky flags: a hardware event in the clearing cycle wins over the clear
   assign nmi_evt   = {flash_acc_viol_i, osc_fault_evt_i, nmi_pin_evt_i};
   assign rst_evt_v = {illegal_fetch_evt_i, key_viol_evt_i, watchdog_evt_i,
                       pin_reset_evt_i, 1'b0};
   generate
      for (genvar g = 0; g < 3; g++) begin : g_nmi_flg
         assign nmi_flg_d[g] = nmi_evt[g] | (nmi_flg_q[g] & ~nmi_wclr[g]);   // RQ6 RQ16
      end
      for (genvar g = 0; g < 5; g++) begin : g_rst_flg
         assign rst_flg_d[g] = rst_evt_v[g] | (rst_flg_q[g] & ~rst_wclr[g]);
      end
   endgenerate

   // wishbone slave: answers every access one cycle later, unmapped reads zero
   always_comb begin
      ack_d      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wr         = ack_d & wb_we_i;
      wmask      = wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);           // RQ18
      nmi_wclr   = '0;
      rst_wclr   = '0;
      ctrl_ext_d = ctrl_ext_q;
      nmi_en_d   = nmi_en_q;
      single_d   = single_q;
      rdat_d     = '0;
      if (wr) begin
         unique case ({wb_adr_i[7:2], 2'b00})
            ieu_pkg::REG_CTRL: ctrl_ext_d =
               wmask[ieu_pkg::CTRL_EXT_BIT] | (ctrl_ext_q & ~wb_sel_i[0]);
            ieu_pkg::REG_NMI_EN:  nmi_en_d = 3'(wmerge(32'(nmi_en_q), wb_dat_i, wb_sel_i));
            ieu_pkg::REG_NMI_FLG: nmi_wclr = 3'(wmask);
            ieu_pkg::REG_RST_FLG: rst_wclr = 5'(wmask);
            ieu_pkg::REG_SINGLE:  single_d = 30'(wmerge(32'(single_q), wb_dat_i, wb_sel_i));
            default: ;
         endcase
      end
      if (nmi_clr) begin
         nmi_en_d = '0;                                                  // RQ20
      end
      if (ack_d && !wb_we_i) begin
         unique case ({wb_adr_i[7:2], 2'b00})
            ieu_pkg::REG_CTRL:    rdat_d = 32'(ctrl_ext_q);
            ieu_pkg::REG_NMI_EN:  rdat_d = 32'(nmi_en_q);
            ieu_pkg::REG_NMI_FLG: rdat_d = 32'(nmi_flg_q);
            ieu_pkg::REG_RST_FLG: rdat_d = 32'(rst_flg_q);
            ieu_pkg::REG_SINGLE:  rdat_d = 32'(single_q);
            ieu_pkg::REG_STATUS:  rdat_d = 32'({busy_o, sel_q});
            default:              rdat_d = '0;
         endcase
      end
   end

   // register file; power-on flag is set by the reset itself
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= '0;
         ctrl_ext_q <= 1'b0;
         nmi_en_q   <= '0;
         nmi_flg_q  <= '0;
         rst_flg_q  <= 5'h01;
         single_q   <= '0;
      end else begin
         wb_ack_o   <= ack_d;
         wb_dat_o   <= rdat_d;
         ctrl_ext_q <= ctrl_ext_d;
         nmi_en_q   <= nmi_en_d;
         nmi_flg_q  <= nmi_flg_d;
         rst_flg_q  <= rst_flg_d;
         single_q   <= single_d;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_entry_lat_ext: assert property (accept && ctrl_ext_q |-> ##5 isr_start_o) // RQ1
      else $error("extended entry latency not 5");
   a_entry_lat_base: assert property (accept && !ctrl_ext_q |-> ##6 isr_start_o) // RQ1
      else $error("base entry latency not 6");
   a_at_boundary: assert property (accept |-> instr_done_i || sr_i[ieu_pkg::SR_SLEEP_BIT]) // RQ2
      else $error("entry taken inside an instruction");
   a_push_pc_first: assert property (accept |-> ##2 (stk_o.push && stk_o.data == $past(pc_i, 2))) // RQ3
      else $error("first push is not the program counter");
   a_push_sr_next: assert property (accept |-> ##3 (stk_o.push && stk_o.data == $past(sr_i, 3))) // RQ4
      else $error("second push is not the status word");
   a_pick_highest: assert property (accept |-> (pend >> (32'(pend_idx) + 1)) == '0) // RQ5
      else $error("lower priority request selected");
   a_single_ack: assert property (accept && pend_idx < ieu_pkg::IDX_NMI && single_q[pend_idx]
      |-> ##4 irq_ack_o == (30'h0000_0001 << $past(pend_idx, 4))) // RQ6
      else $error("single source not acknowledged once");
   a_sr_cleared: assert property (accept |-> ##4 (core_o.sr_load && core_o.sr_val == '0)) // RQ7
      else $error("status word not cleared on entry");
   a_vec_loaded: assert property (vec_rd_o && state_q == ieu_pkg::ST_ENTRY
      |=> core_o.pc_load && core_o.pc_val == $past(vec_data_i)) // RQ8
      else $error("vector word not loaded");
   a_vec_addr: assert property (accept |-> ##4 (vec_rd_o
      && vec_addr_o == ieu_pkg::VEC_BASE + {10'h000, $past(pend_idx, 4), 1'b0})) // RQ13
      else $error("vector address wrong");
   a_ret_lat_ext: assert property (ret_go && ctrl_ext_q |-> ##3 ret_done_o) // RQ9
      else $error("extended return latency not 3");
   a_ret_lat_base: assert property (ret_go && !ctrl_ext_q |-> ##5 ret_done_o) // RQ9
      else $error("base return latency not 5");
   a_ret_order: assert property (ret_go |-> ##1 stk_o.pop ##1 (core_o.sr_load && stk_o.pop)
      ##1 (core_o.pc_load && !core_o.sr_load)) // RQ10
      else $error("return pops out of order");
   a_nmi_en_clear: assert property (accept && pend_idx == ieu_pkg::IDX_NMI |=> nmi_en_q == '0) // RQ20
      else $error("non-maskable enables not cleared");
   a_mask_glob: assert property (accept && pend_idx < ieu_pkg::IDX_NMI |-> irq_on) // RQ19
      else $error("maskable request taken without global enable");

   c_entry: cover property (accept ##5 isr_start_o);
   c_return: cover property (ret_go ##[3:5] ret_done_o);
   c_nmi: cover property (accept && pend_idx == ieu_pkg::IDX_NMI);
   c_nested: cover property (accept && $past(state_q) == ieu_pkg::ST_IDLE && sr_sav_d[3]);
endmodule // ieu_entry_return

/* File: verif/ieu_core_model.sv */
// core datapath stand-in: lifo stack, vector memory, pc and status word
`timescale 1ns/1ps
module ieu_core_model (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire ieu_pkg::ieu_stk_t  stk_i,
   input  wire ieu_pkg::ieu_core_t core_i,
   input  wire logic               vec_rd_i,
   input  wire logic [15:0]        vec_addr_i,
   input  wire logic               sw_we_i,
   input  wire logic [15:0]        sw_sr_i,
   output logic      [15:0]        pop_data_o,
   output logic      [15:0]        vec_data_o,
   output logic      [15:0]        sr_o,
   output logic      [15:0]        pc_o
);
   logic [15:0] stack_q [16];
   logic [3:0]  sp_q;
   logic [15:0] top_w;
   logic [15:0] vword_w;
   // every slot holds a full handler address, so no vector is left unserved
   assign vword_w    = {vec_addr_i[7:0], ~vec_addr_i[7:0]};
   assign top_w      = stack_q[sp_q - 4'h1];
   // unread ports show inverted data, so a stale sample never matches by luck
   assign pop_data_o = stk_i.pop ? top_w : ~top_w;
   assign vec_data_o = vec_rd_i ? vword_w : ~vword_w;
   // stack pointer, pc and status word; hardware loads win over software writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sp_q <= 4'h0;
         sr_o <= 16'h0000;
         pc_o <= 16'h0000;
      end else begin
         if (stk_i.push) stack_q[sp_q] <= stk_i.data;
         sp_q <= sp_q + 4'(stk_i.push) - 4'(stk_i.pop);
         if (core_i.sr_load) sr_o <= core_i.sr_val;
         else if (sw_we_i) sr_o <= sw_sr_i;
         if (core_i.pc_load) pc_o <= core_i.pc_val;
      end
   end
endmodule // ieu_core_model

/* File: verif/irq_entry_return_unit_tb_top.sv */
// self-checking bench for the interrupt entry and return sequencer
`timescale 1ns/1ps
module irq_entry_return_unit_tb_top;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        done = 1'b0, rti = 1'b0, sw_we = 1'b0, wb_ack_o, vec_rd_o, busy_o;
   logic        isr_start_o, ret_done_o;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0, rst_ev = 4'h0;
   logic [2:0]  nmi_ev = 3'h0;
   logic [31:0] wdat = 32'h0000_0000, wb_dat_o;
   logic [29:0] irq = 30'h0000_0000, irq_ack_o, msk, ack_acc;
   logic [15:0] pc_r = 16'h0000, sw_sr = 16'h0000, vec_addr_o, pop_d, vec_d, sr_w, pc_w;
   logic [15:0] vaddr_last;
   logic [15:0] push_q[$];
   ieu_pkg::ieu_stk_t  stk_o;
   ieu_pkg::ieu_core_t core_o;
   int          num_errors = 0, cmp_count = 0, cycles = 0;

   ieu_entry_return ieu_entry_return_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_done_i(done), .ret_req_i(rti),
      .pc_i(pc_r), .sr_i(sr_w), .pop_data_i(pop_d), .vec_data_i(vec_d), .irq_i(irq),
      .nmi_pin_evt_i(nmi_ev[0]), .osc_fault_evt_i(nmi_ev[1]), .flash_acc_viol_i(nmi_ev[2]),
      .pin_reset_evt_i(rst_ev[0]), .watchdog_evt_i(rst_ev[1]), .key_viol_evt_i(rst_ev[2]),
      .illegal_fetch_evt_i(rst_ev[3]), .stk_o(stk_o), .core_o(core_o), .vec_rd_o(vec_rd_o),
      .vec_addr_o(vec_addr_o), .irq_ack_o(irq_ack_o), .busy_o(busy_o),
      .isr_start_o(isr_start_o), .ret_done_o(ret_done_o));
   ieu_core_model ieu_core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .stk_i(stk_o),
      .core_i(core_o), .vec_rd_i(vec_rd_o), .vec_addr_i(vec_addr_o), .sw_we_i(sw_we),
      .sw_sr_i(sw_sr), .pop_data_o(pop_d), .vec_data_o(vec_d), .sr_o(sr_w), .pc_o(pc_w));

   always #5 clk_i = ~clk_i;

   // record pushes, vector reads and acknowledges; cut a hang short
   always @(posedge clk_i) begin
      if (stk_o.push === 1'b1) push_q.push_back(stk_o.data);
      if (vec_rd_o === 1'b1) vaddr_last = vec_addr_o;
      ack_acc = ack_acc | irq_ack_o;
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         print_verdict();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // classic cycle: hold everything until ack is sampled, then release
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] r);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
   endtask

   // count edges until start or return-done is seen; one more edge lets loads land
   task automatic wait_end(input logic on_ret, output int n);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
         {nmi_ev, rst_ev, rti} <= 8'h00;
      end while ((on_ret ? ret_done_o : isr_start_o) !== 1'b1);
      @(posedge clk_i);
   endtask

   task automatic set_sr(input logic [15:0] v);
      {sw_we, sw_sr} <= {1'b1, v};
      @(posedge clk_i);
      sw_we <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic entry(input int idx, input logic ext, input logic [29:0] pend,
                        output logic [15:0] sr0, output logic [15:0] pc0);
      int n;
      logic [15:0] va;
      sr0 = sr_w;
      pc0 = 16'($urandom);
      va = 16'hFFC0 + 16'(2 * idx);
      push_q.delete();
      ack_acc = '0;
      {pc_r, irq, done} <= {pc0, pend, 1'b1};
      wait_end(1'b0, n);
      chk("entry cycles", (ext ? 6 : 7) + 32'(idx == 30), n);
      chk("push count", 2, push_q.size());
      chk("pushed pc", pc0, push_q[0]);
      chk("pushed sr", sr0, push_q[1]);
      chk("vector addr", va, vaddr_last);
      chk("handler pc", {va[7:0], ~va[7:0]}, pc_w);
      chk("sr cleared", 0, sr_w);
      chk("ack", (idx < 30 && msk[idx]) ? 30'(1) << idx : 30'h0, ack_acc);
      irq <= '0;
      $display("entry to vector %0d done", idx);
   endtask

   task automatic ret(input logic ext, input logic [15:0] sr_e, input logic [15:0] pc_e);
      int n;
      rti <= 1'b1;
      wait_end(1'b1, n);
      chk("return cycles", ext ? 4 : 6, n);
      chk("restored sr", sr_e, sr_w);
      chk("resumed pc", pc_e, pc_w);
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      logic [31:0] r;
      logic [15:0] s0, p0, s1, p1;
      logic [29:0] pend;
      logic        ext;
      int          n, k;
      n = $urandom(32'h0000_11E1);
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_end(1'b0, n);
      chk("reset pc", 16'hFE01, pc_w);
      wb(1'b0, 8'h0C, 4'h1, 0, r);
      chk("power-on flag", 1, r);
      wb(1'b0, 8'hFC, 4'hF, 0, r);
      chk("unmapped read", 0, r);
      msk = 30'($urandom);
      wb(1'b1, 8'h10, 4'hF, 32'(msk), r);
      // pending request blocked first by a clear global enable, then mid-instruction
      {irq, done} <= {30'h0000_0001, 1'b1};
      repeat (6) @(posedge clk_i);
      chk("busy without enable", 0, busy_o);
      done <= 1'b0;
      set_sr(16'h0008);
      repeat (4) @(posedge clk_i);
      chk("busy mid-instruction", 0, busy_o);
      entry(0, 1'b0, 30'h0000_0001, s0, p0);
      ret(1'b0, s0, p0);
      $display("gating test done");
      // random requests on both core variants, each with a nested request
      for (int i = 0; i < 8; i++) begin
         ext = i[0];
         wb(1'b1, 8'h00, 4'h1, 32'(ext), r);
         pend = 30'($urandom) | 30'h0000_0001;
         for (int b = 0; b < 30; b++) if (pend[b]) k = b;
         set_sr(16'($urandom) | 16'h0008);
         entry(k, ext, pend, s0, p0);
         set_sr(16'h0008);
         k = $urandom_range(0, 29);
         entry(k, ext, 30'(1) << k, s1, p1);
         ret(ext, s1, p1);
         ret(ext, s0, p0);
      end
      // each non-maskable source with a clear global enable
      set_sr(16'h0000);
      for (int j = 0; j < 3; j++) begin
         wb(1'b1, 8'h04, 4'h1, 32'h0000_0007, r);
         nmi_ev <= 3'(1) << j;
         entry(30, ext, 30'h0000_0000, s0, p0);
         wb(1'b0, 8'h04, 4'h1, 0, r);
         chk("nmi enables", 0, r);
         wb(1'b0, 8'h08, 4'h1, 0, r);
         chk("nmi flag", 32'(1) << j, r);
         wb(1'b1, 8'h08, 4'h1, 32'h0000_0007, r);
         ret(ext, s0, p0);
      end
      // every reset event goes through the reset vector and sets its own flag
      for (int j = 0; j < 4; j++) begin
         rst_ev <= 4'(1) << j;
         wait_end(1'b0, n);
         chk("reset vector", 16'hFFFE, vaddr_last);
         chk("reset pc", 16'hFE01, pc_w);
         wb(1'b0, 8'h0C, 4'h1, 0, r);
         chk("reset flag", 32'(1) << (j + 1), r & 32'h0000_001E);
         wb(1'b1, 8'h0C, 4'h1, 32'h0000_001F, r);
      end
      $display("reset event test done");
      print_verdict();
   end
endmodule // irq_entry_return_unit_tb_top
